/* File: rtl/network_drive_io_params.sv */
/*
  network parameter bank of the drive fieldbus interface: speed
  reference direction, relay and analog images, can settings.
  assumes a one-cycle parameter write port, a link status input and
  pin-level can power detect.
*/
`timescale 1ns/10ps
// What this block does
// - run-forward bit one: positive means forward, negative reverse.
// - run-forward bit zero: positive means reverse, negative forward.
// - speed magnitude saturates at 32767, so -32768 gives 32767.
// - relay image bits 0 to 3 close relay outputs 1 to 4.
// - a relay follows its image bit only when selected for network.
// - analog values use 15-bit scale, 7fff is full output.
// - analog output uses network value only when its function selects it.
// - bipolar outputs take signed values across -10 V to +10 V.
// - analog value parameters refuse writes from the local panel.
// - protocol code 1 is canopen, 2 devicenet, default 2.
// - new protocol applies only while link unpowered, autobaud, or reset.
// - node number 0 to 127, default 63, checked per protocol.
// - new node number applies only while unpowered, autobaud, or reset.
// - bit-rate codes 0 to 8; codes 0,1,5-8 autodetect under devicenet.
// - devicenet fixed rates only 500, 250, 125 kbit/s, else autodetect.
// - a detected rate overwrites the bit-rate code.
module network_drive_io_params
  import drive_io_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // parameter write/read port
  input  wire logic        paramWrite,
  input  wire logic        paramFromPanel,
  input  wire logic [3:0]  paramIndex,
  input  wire logic [15:0] paramWdata,
  output logic [15:0]      paramRdata,
  output logic             paramReject,
  // can link status
  input  wire logic        canPowerPin,
  input  wire logic        linkAutobaud,
  input  wire logic        rateDetected,
  input  wire logic [3:0]  detectedRateCode,
  // output function selections
  input  wire logic [3:0]  relayFromNetwork,
  input  wire logic [3:0]  relayLocal,
  input  wire logic [1:0]  analogOutputFunctionA,
  input  wire logic [1:0]  analogOutputFunctionB,
  input  wire logic [1:0]  analogBipolar,
  input  wire logic [15:0] analogLocalA,
  input  wire logic [15:0] analogLocalB,
  // drive outputs
  output logic             runForward,
  output logic [15:0]      speedMagnitude,
  output logic [3:0]       relayOutputs,
  output logic [15:0]      analogOutA,
  output logic [15:0]      analogOutB,
  output logic             analogNetA,
  output logic             analogNetB,
  // active can settings
  output logic             protocolCanopen,
  output logic [6:0]       activeNode,
  output logic [3:0]       activeRateCode,
  output logic             autobaudRun
);
  // ----------------------------------------
  // parameter storage
  // ----------------------------------------
  logic [15:0] commandWordReg;
  logic [15:0] speedRefReg;
  logic [3:0]  relayImageReg;
  logic [15:0] aoutOneReg;
  logic [15:0] aoutTwoReg;
  logic [15:0] protocolReg;
  logic [15:0] nodeReg;
  logic [15:0] rateReg;
  logic [15:0] activeProtoReg;
  logic        canPowered;
  logic        linkIdle;
  logic        wrOk;
  logic        inRange;
  logic signed [15:0] speedSigned;
  logic signed [16:0] speedNeg;
  logic        fwdNext;
  logic [15:0] magNext;

  pin_sync #(.RESET_VAL(1'b0)) u_power_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pinIn   (canPowerPin),
    .levelOut(canPowered)
  );

  assign linkIdle = !canPowered || linkAutobaud;

  // range check against the protocol in force
  always_comb begin
    inRange = 1'b1;
    unique case (paramIndex)
      IDX_RELAY:    inRange = (paramWdata <= RELAY_MAX);
      IDX_AOUT_ONE,
      IDX_AOUT_TWO: inRange = !paramFromPanel;
      IDX_PROTOCOL: inRange = (paramWdata == PROTO_CANOPEN)
                           || (paramWdata == PROTO_DEVICENET);
      IDX_NODE: begin
        if (activeProtoReg == PROTO_CANOPEN) begin
          inRange = (paramWdata >= NODE_CO_MIN)
                 && (paramWdata <= NODE_MAX);
        end else begin
          inRange = (paramWdata <= NODE_DN_MAX);
        end
      end
      IDX_BITRATE:  inRange = (paramWdata <= RATE_MAX);
      IDX_COMMAND,
      IDX_SPEED_REF: inRange = !paramFromPanel;
      default:      inRange = 1'b0;
    endcase
  end

  assign wrOk = paramWrite && inRange;

  // ----------------------------------------
  // drive command parameters
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      commandWordReg <= 16'h0000;
      speedRefReg    <= 16'h0000;
    end else if (wrOk) begin
      if (paramIndex == IDX_COMMAND) begin
        commandWordReg <= paramWdata;
      end
      if (paramIndex == IDX_SPEED_REF) begin
        speedRefReg <= paramWdata;
      end
    end
  end

  // ----------------------------------------
  // output images
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      relayImageReg <= 4'h0;
      aoutOneReg    <= 16'h0000;
      aoutTwoReg    <= 16'h0000;
    end else if (wrOk) begin
      if (paramIndex == IDX_RELAY) begin
        relayImageReg <= paramWdata[3:0];
      end
      if (paramIndex == IDX_AOUT_ONE) begin
        aoutOneReg <= paramWdata;
      end
      if (paramIndex == IDX_AOUT_TWO) begin
        aoutTwoReg <= paramWdata;
      end
    end
  end

  // ----------------------------------------
  // can configuration
  // ----------------------------------------
  // a detection result wins over a write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      protocolReg <= PROTO_RESET;
      nodeReg     <= NODE_RESET;
      rateReg     <= RATE_RESET;
    end else begin
      if (wrOk && paramIndex == IDX_PROTOCOL) begin
        protocolReg <= paramWdata;
      end
      if (wrOk && paramIndex == IDX_NODE) begin
        nodeReg <= paramWdata;
      end
      if (rateDetected && autobaudRun) begin
        rateReg <= {12'h000, detectedRateCode};
      end else if (wrOk && paramIndex == IDX_BITRATE) begin
        rateReg <= paramWdata;
      end
    end
  end

  // settings in force change only while the link is idle or after reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      activeProtoReg  <= PROTO_RESET;
      protocolCanopen <= 1'b0;
      activeNode      <= 7'(NODE_RESET);
      activeRateCode  <= 4'(RATE_RESET);
    end else if (linkIdle) begin
      activeProtoReg  <= protocolReg;
      protocolCanopen <= (protocolReg == PROTO_CANOPEN);
      activeNode      <= nodeReg[6:0];
      activeRateCode  <= rateReg[3:0];
    end
  end

  // only 500, 250 and 125 are fixed under devicenet
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      autobaudRun <= 1'b0;
    end else begin
      autobaudRun <= (activeProtoReg == PROTO_DEVICENET)
                  && ((rateReg < RATE_500K)
                   || (rateReg > RATE_125K));
    end
  end

  // ----------------------------------------
  // speed reference direction
  // ----------------------------------------
  // 8192 counts = rated frequency; the word is kept as is
  assign speedSigned = $signed(speedRefReg);
  assign speedNeg    = -{speedSigned[15], speedSigned};

  always_comb begin
    fwdNext = commandWordReg[RUN_FWD_BIT];
    magNext = speedRefReg;
    if (speedSigned < 0) begin
      fwdNext = !commandWordReg[RUN_FWD_BIT];
      // -32768 has no positive twin, so it saturates
      magNext = (speedNeg > 17'(SPEED_POS_SAT))
              ? SPEED_POS_SAT : speedNeg[15:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      runForward     <= 1'b1;
      speedMagnitude <= 16'h0000;
    end else begin
      runForward     <= fwdNext;
      speedMagnitude <= magNext;
    end
  end

  // ----------------------------------------
  // relay and analog outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      relayOutputs <= 4'h0;
    end else begin
      relayOutputs <= (relayFromNetwork & relayImageReg)
                    | (~relayFromNetwork & relayLocal);
    end
  end

  aout_select u_aout_a (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .functionSel(analogOutputFunctionA),
    .bipolar    (analogBipolar[0]),
    .localValue (analogLocalA),
    .valueOne   (aoutOneReg),
    .valueTwo   (aoutTwoReg),
    .levelOut   (analogOutA),
    .fromNetwork(analogNetA)
  );

  aout_select u_aout_b (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .functionSel(analogOutputFunctionB),
    .bipolar    (analogBipolar[1]),
    .localValue (analogLocalB),
    .valueOne   (aoutOneReg),
    .valueTwo   (aoutTwoReg),
    .levelOut   (analogOutB),
    .fromNetwork(analogNetB)
  );

  // ----------------------------------------
  // read-back and reject flag
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      paramRdata  <= 16'h0000;
      paramReject <= 1'b0;
    end else begin
      paramReject <= paramWrite && !inRange;
      unique case (paramIndex)
        IDX_COMMAND:   paramRdata <= commandWordReg;
        IDX_SPEED_REF: paramRdata <= speedRefReg;
        IDX_RELAY:     paramRdata <= {12'h000, relayImageReg};
        IDX_AOUT_ONE:  paramRdata <= aoutOneReg;
        IDX_AOUT_TWO:  paramRdata <= aoutTwoReg;
        IDX_PROTOCOL:  paramRdata <= protocolReg;
        IDX_NODE:      paramRdata <= nodeReg;
        IDX_BITRATE:   paramRdata <= rateReg;
        IDX_LINK_STAT: paramRdata <= {14'h0000, autobaudRun, canPowered};
        default:       paramRdata <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_reject_keeps;
    @(posedge clk_sys) disable iff (!reset_n)
    (paramWrite && !inRange && paramIndex == IDX_NODE)
      |=> $stable(nodeReg);
  endproperty
  a_reject_keeps: assert property (p_reject_keeps)
    else $error("rejected node write changed the value");

  property p_panel_refused;
    @(posedge clk_sys) disable iff (!reset_n)
    (paramWrite && paramFromPanel && paramIndex == IDX_AOUT_ONE)
      |=> $stable(aoutOneReg) && paramReject;
  endproperty
  a_panel_refused: assert property (p_panel_refused)
    else $error("panel write reached analog value");

  property p_fwd_dir;
    @(posedge clk_sys) disable iff (!reset_n)
    (commandWordReg[RUN_FWD_BIT] && speedSigned > 0) |=> runForward;
  endproperty
  a_fwd_dir: assert property (p_fwd_dir)
    else $error("positive reference with run bit not forward");

  property p_inv_dir;
    @(posedge clk_sys) disable iff (!reset_n)
    (!commandWordReg[RUN_FWD_BIT] && speedSigned > 0) |=> !runForward;
  endproperty
  a_inv_dir: assert property (p_inv_dir)
    else $error("inverted sense not applied");

  property p_sat;
    @(posedge clk_sys) disable iff (!reset_n)
    (speedRefReg == 16'h8000) |=> speedMagnitude == SPEED_POS_SAT;
  endproperty
  a_sat: assert property (p_sat)
    else $error("speed magnitude not saturated");

  property p_relay;
    @(posedge clk_sys) disable iff (!reset_n)
    relayFromNetwork[0] |=> relayOutputs[0] == $past(relayImageReg[0]);
  endproperty
  a_relay: assert property (p_relay)
    else $error("relay 1 does not follow image");

  property p_node_hold;
    @(posedge clk_sys) disable iff (!reset_n)
    (!linkIdle && $changed(nodeReg)) |=> $stable(activeNode);
  endproperty
  a_node_hold: assert property (p_node_hold)
    else $error("node applied while link active");

  property p_proto_hold;
    @(posedge clk_sys) disable iff (!reset_n)
    !linkIdle |=> $stable(protocolCanopen);
  endproperty
  a_proto_hold: assert property (p_proto_hold)
    else $error("protocol changed while link active");

  property p_proto_legal;
    @(posedge clk_sys) disable iff (!reset_n)
    (protocolReg == PROTO_CANOPEN) || (protocolReg == PROTO_DEVICENET);
  endproperty
  a_proto_legal: assert property (p_proto_legal)
    else $error("illegal protocol stored");

  property p_detect;
    @(posedge clk_sys) disable iff (!reset_n)
    (rateDetected && autobaudRun)
      |=> rateReg == {12'h000, $past(detectedRateCode)};
  endproperty
  a_detect: assert property (p_detect)
    else $error("detected rate not stored");

  c_reject: cover property (@(posedge clk_sys) paramReject);
  c_reverse: cover property (@(posedge clk_sys) !runForward);
  c_autobaud: cover property (@(posedge clk_sys) autobaudRun);
  c_apply: cover property (@(posedge clk_sys)
    linkIdle && $changed(activeNode));
endmodule

/* File: rtl/drive_io_pkg.sv */
/*
  constants shared by the network drive i/o parameter block.
  assumes a single clock domain and a parameter write port.
*/
package drive_io_pkg;
  // ----------------------------------------
  // parameter indices on the write/read port
  // ----------------------------------------
  localparam logic [3:0] IDX_COMMAND   = 4'h0;
  localparam logic [3:0] IDX_SPEED_REF = 4'h1;
  localparam logic [3:0] IDX_RELAY     = 4'h2;
  localparam logic [3:0] IDX_AOUT_ONE  = 4'h3;
  localparam logic [3:0] IDX_AOUT_TWO  = 4'h4;
  localparam logic [3:0] IDX_PROTOCOL  = 4'h5;
  localparam logic [3:0] IDX_NODE      = 4'h6;
  localparam logic [3:0] IDX_BITRATE   = 4'h7;
  localparam logic [3:0] IDX_LINK_STAT = 4'h8;

  // ----------------------------------------
  // field positions and codes
  // ----------------------------------------
  localparam int RUN_FWD_BIT = 2;
  localparam logic [15:0] PROTO_CANOPEN   = 16'h0001;
  localparam logic [15:0] PROTO_DEVICENET = 16'h0002;
  localparam logic [15:0] PROTO_RESET     = 16'h0002;
  localparam logic [15:0] NODE_RESET      = 16'h003f;
  localparam logic [15:0] NODE_MAX        = 16'h007f;
  localparam logic [15:0] NODE_DN_MAX     = 16'h003f;
  localparam logic [15:0] NODE_CO_MIN     = 16'h0001;
  localparam logic [15:0] RATE_RESET      = 16'h0000;
  localparam logic [15:0] RATE_MAX        = 16'h0008;
  localparam logic [15:0] RATE_500K       = 16'h0002;
  localparam logic [15:0] RATE_125K       = 16'h0004;
  localparam logic [15:0] RELAY_MAX       = 16'h000f;
  localparam logic [15:0] AOUT_UNI_MAX    = 16'h7fff;
  localparam logic signed [15:0] SPEED_POS_SAT = 16'sh7fff;
  localparam logic signed [15:0] SPEED_NEG_SAT = -16'sh8000;
  localparam logic signed [15:0] RATED_COUNTS  = 16'sh2000;

  // analog output source selections
  localparam logic [1:0] AOUT_SRC_LOCAL = 2'h0;
  localparam logic [1:0] AOUT_SRC_ONE   = 2'h1;
  localparam logic [1:0] AOUT_SRC_TWO   = 2'h2;

  typedef enum logic [1:0] {LINK_OFF, LINK_AUTOBAUD, LINK_ACTIVE} link_t;
endpackage

/* File: rtl/pin_sync.sv */
/*
  three-stage synchroniser with agreement filter for one pin level.
  assumes the level is slow against clk_sys.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // pin and filtered level
  input  wire logic pinIn,
  output logic      levelOut
);
  logic s1Reg;
  logic s2Reg;
  logic s3Reg;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s1Reg <= RESET_VAL;
      s2Reg <= RESET_VAL;
      s3Reg <= RESET_VAL;
    end else begin
      s1Reg <= pinIn;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      levelOut <= RESET_VAL;
    end else if (s2Reg == s3Reg) begin
      levelOut <= s3Reg;
    end
  end
endmodule

/* File: rtl/aout_select.sv */
/*
  source selection for one analog output channel.
  assumes the value parameters are already range checked.
*/
`timescale 1ns/10ps
module aout_select
  import drive_io_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // selection and sources
  input  wire logic [1:0]  functionSel,
  input  wire logic        bipolar,
  input  wire logic [15:0] localValue,
  input  wire logic [15:0] valueOne,
  input  wire logic [15:0] valueTwo,
  // result
  output logic [15:0]      levelOut,
  output logic             fromNetwork
);
  logic [15:0] pick;

  always_comb begin
    pick = localValue;
    if (functionSel == AOUT_SRC_ONE) begin
      pick = valueOne;
    end else if (functionSel == AOUT_SRC_TWO) begin
      pick = valueTwo;
    end
  end

  // unipolar never goes below zero; bipolar passes the signed word
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      levelOut    <= 16'h0000;
      fromNetwork <= 1'b0;
    end else begin
      levelOut    <= (bipolar || !pick[15]) ? pick : 16'h0000;
      fromNetwork <= (functionSel != AOUT_SRC_LOCAL);
    end
  end
endmodule

/* File: dv/can_link_model.sv */
/*
  partner model: can link side seen by the parameter bank.
  assumes bench requests change only just after a clock edge.
*/
`timescale 1ns/10ps
module can_link_model (
  // clock
  input  wire logic       clk_sys,
  // bench requests
  input  wire logic       powerReq,
  input  wire logic       autobaudReq,
  input  wire logic       detectReq,
  input  wire logic [3:0] detectCode,
  // link signals
  output logic            canPowerPin,
  output logic            linkAutobaud,
  output logic            rateDetected,
  output logic [3:0]      detectedRateCode
);
  initial begin
    canPowerPin = 1'b0;
    linkAutobaud = 1'b0;
    rateDetected = 1'b0;
    detectedRateCode = 4'h0;
  end
  // one node on the segment, so its address is always unique
  always @(posedge clk_sys) begin
    canPowerPin <= powerReq;
    linkAutobaud <= autobaudReq;
    rateDetected <= detectReq;
    // code is only meaningful with the pulse, so it toggles otherwise
    detectedRateCode <= detectReq ? detectCode : ~detectedRateCode;
  end
endmodule

/* File: dv/network_drive_io_params_tb.sv */
/*
  self-checking bench of the drive parameter bank.
  assumes can_link_model as link partner and a 250 MHz clock.
*/
`timescale 1ns/10ps
module network_drive_io_params_tb;
  import drive_io_pkg::*;
  logic        clk_sys, reset_n, paramWrite, paramFromPanel, rdReq;
  logic [3:0]  paramIndex, relayFromNetwork, relayLocal, detectCode;
  logic [15:0] paramWdata, paramRdata, analogLocalA, analogLocalB;
  logic        paramReject, canPowerPin, linkAutobaud, rateDetected;
  logic [3:0]  detectedRateCode, relayOutputs, activeRateCode;
  logic [1:0]  analogOutputFunctionA, analogOutputFunctionB;
  logic [1:0]  analogBipolar;
  logic        runForward, analogNetA, analogNetB, protocolCanopen;
  logic [15:0] speedMagnitude, analogOutA, analogOutB, aVal;
  logic [6:0]  activeNode;
  logic        autobaudRun, powerReq, autobaudReq, detectReq;
  logic        wrSeen, rdSeen;
  logic [3:0]  img;
  logic [15:0] rdQ[$];
  logic        rejQ[$];
  int          mismatches, comparisons, cycles;
  logic [15:0] spd [6] = '{16'h1000, 16'hf000, 16'h1000, 16'hf000,
                           16'h8000, 16'h7fff};
  logic        fwdB [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  logic        expF [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [15:0] expM [6] = '{16'h1000, 16'h1000, 16'h1000, 16'h1000,
                            16'h7fff, 16'h7fff};

  network_drive_io_params u_dut (.*);
  can_link_model u_link (.clk_sys(clk_sys), .powerReq(powerReq),
    .autobaudReq(autobaudReq), .detectReq(detectReq),
    .detectCode(detectCode), .canPowerPin(canPowerPin),
    .linkAutobaud(linkAutobaud), .rateDetected(rateDetected),
    .detectedRateCode(detectedRateCode));

  // ----------------------------------------
  // compare tasks and scoreboard
  // ----------------------------------------
  task automatic chkWord(input string n, input logic [15:0] e,
                         input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkBit(input string n, input logic e, input logic g);
    chkWord(n, {15'h0, e}, {15'h0, g});
  endtask
  // results appear one edge after the request was sampled
  always @(posedge clk_sys) begin
    wrSeen <= paramWrite;
    rdSeen <= rdReq;
    if (wrSeen) begin
      chkBit("paramReject", rejQ.pop_front(), paramReject);
    end
    if (rdSeen) begin
      chkWord("paramRdata", rdQ.pop_front(), paramRdata);
    end
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic wr(input logic [3:0] i, input logic [15:0] d,
                    input logic pnl, input logic rej);
    @(posedge clk_sys);
    paramWrite <= 1'b1;
    paramIndex <= i;
    paramWdata <= d;
    paramFromPanel <= pnl;
    rejQ.push_back(rej);
    @(posedge clk_sys);
    paramWrite <= 1'b0;
    paramFromPanel <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] i, input logic [15:0] e);
    @(posedge clk_sys);
    paramIndex <= i;
    rdReq <= 1'b1;
    rdQ.push_back(e);
    @(posedge clk_sys);
    rdReq <= 1'b0;
  endtask
  // outputs are registered and the power pin is synchronised first
  // inputs stay on the edge; outputs read here have stood for cycles
  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      test_done();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset_n, paramWrite, paramFromPanel, rdReq, detectReq} = '0;
    {paramIndex, paramWdata, detectCode, relayFromNetwork} = '0;
    {relayLocal, analogLocalA, analogLocalB, analogBipolar} = '0;
    {analogOutputFunctionA, analogOutputFunctionB, autobaudReq} = '0;
    {mismatches, comparisons, cycles} = '0;
    powerReq = 1'b1;
    void'($urandom(68));
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(IDX_PROTOCOL, PROTO_RESET);
    rd(IDX_NODE, NODE_RESET);
    rd(IDX_BITRATE, RATE_RESET);
    settle();
    chkBit("protocolCanopen", 1'b0, protocolCanopen);
    chkWord("activeNode", 16'd63, {9'h0, activeNode});
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      wr(IDX_COMMAND, 16'(fwdB[i]) << RUN_FWD_BIT, 1'b0, 1'b0);
      wr(IDX_SPEED_REF, spd[i], 1'b0, 1'b0);
      settle();
      chkBit("runForward", expF[i], runForward);
      chkWord("speedMagnitude", expM[i], speedMagnitude);
    end
    wr(IDX_SPEED_REF, 16'h0001, 1'b1, 1'b1);
    $display("test speed done");
    for (int i = 0; i < 4; i++) begin
      img = 4'($urandom_range(15));
      relayFromNetwork <= 4'($urandom_range(15));
      relayLocal <= 4'($urandom_range(15));
      wr(IDX_RELAY, {12'h0, img}, 1'b0, 1'b0);
      settle();
      img = (img & relayFromNetwork) | (relayLocal & ~relayFromNetwork);
      chkWord("relayOutputs", {12'h0, img}, {12'h0, relayOutputs});
    end
    wr(IDX_RELAY, 16'h0010, 1'b0, 1'b1);
    $display("test relay done");
    aVal = 16'($urandom_range(32767));
    analogLocalA <= 16'($urandom_range(32767));
    analogOutputFunctionA <= AOUT_SRC_ONE;
    analogOutputFunctionB <= AOUT_SRC_TWO;
    analogBipolar <= 2'b10;
    wr(IDX_AOUT_ONE, aVal, 1'b0, 1'b0);
    wr(IDX_AOUT_ONE, 16'h1234, 1'b1, 1'b1);
    wr(IDX_AOUT_TWO, 16'hc000, 1'b0, 1'b0);
    rd(IDX_AOUT_ONE, aVal);
    settle();
    chkWord("analogOutA", aVal, analogOutA);
    chkBit("analogNetA", 1'b1, analogNetA);
    chkWord("analogOutB", 16'hc000, analogOutB);
    chkBit("analogNetB", 1'b1, analogNetB);
    analogOutputFunctionA <= AOUT_SRC_LOCAL;
    settle();
    chkWord("analogOutA", analogLocalA, analogOutA);
    chkBit("analogNetA", 1'b0, analogNetA);
    // unipolar output A takes the negative word of value two: clamps to 0
    analogOutputFunctionA <= AOUT_SRC_TWO;
    settle();
    chkWord("analogOutA", 16'h0000, analogOutA);
    $display("test analog done");
    wr(IDX_NODE, 16'd64, 1'b0, 1'b1);
    wr(IDX_NODE, 16'd10, 1'b0, 1'b0);
    wr(IDX_PROTOCOL, PROTO_CANOPEN, 1'b0, 1'b0);
    wr(IDX_PROTOCOL, 16'h0003, 1'b0, 1'b1);
    settle();
    chkBit("protocolCanopen", 1'b0, protocolCanopen);
    chkWord("activeNode", 16'd63, {9'h0, activeNode});
    powerReq <= 1'b0;
    settle();
    chkBit("protocolCanopen", 1'b1, protocolCanopen);
    chkWord("activeNode", 16'd10, {9'h0, activeNode});
    wr(IDX_NODE, 16'd0, 1'b0, 1'b1);
    wr(IDX_NODE, 16'd128, 1'b0, 1'b1);
    wr(IDX_BITRATE, 16'd9, 1'b0, 1'b1);
    wr(4'h9, 16'h0001, 1'b0, 1'b1);
    rd(4'h9, 16'h0000);
    rd(IDX_NODE, 16'd10);
    powerReq <= 1'b1;
    autobaudReq <= 1'b1;
    wr(IDX_NODE, 16'd100, 1'b0, 1'b0);
    settle();
    chkWord("activeNode", 16'd100, {9'h0, activeNode});
    $display("test can settings done");
    powerReq <= 1'b0;
    wr(IDX_NODE, 16'd20, 1'b0, 1'b0);
    wr(IDX_PROTOCOL, PROTO_DEVICENET, 1'b0, 1'b0);
    for (int c = 0; c < 9; c++) begin
      wr(IDX_BITRATE, 16'(c), 1'b0, 1'b0);
      settle();
      chkBit("autobaudRun", !(c inside {2, 3, 4}), autobaudRun);
      chkWord("activeRateCode", 16'(c), {12'h0, activeRateCode});
    end
    @(posedge clk_sys);
    detectCode <= 4'h3;
    detectReq <= 1'b1;
    @(posedge clk_sys);
    detectReq <= 1'b0;
    settle();
    rd(IDX_BITRATE, 16'h0003);
    settle();
    chkBit("autobaudRun", 1'b0, autobaudRun);
    $display("test bit rate done");
    test_done();
  end
endmodule
